/* File: hw/pin_sync.sv */
/*
  Three-flop synchroniser for a bus of pins; output changes once the
  second and third stages agree.
  Assumes a single clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
module pin_sync #(
  parameter int width = 8
) (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Pins and synchronised levels
  input  wire logic [width-1:0] async_in,
  output logic      [width-1:0] sync_out
);
  logic [width-1:0] s1_reg;
  logic [width-1:0] s2_reg;
  logic [width-1:0] s3_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // Per bit: take the new level only when the last two stages agree
  genvar i;
  generate
    for (i = 0; i < width; i++) begin : g_bit
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sync_out[i] <= 1'b0;
        end else if (s2_reg[i] == s3_reg[i]) begin
          sync_out[i] <= s3_reg[i];
        end
      end
    end
  endgenerate
endmodule

/* File: hw/port_io_config.sv */
/*
  General-purpose port block: ports L, G, C, F (bidirectional) and D (output
  only), reached over APB; per-bit pin mode decode and port G special bits.
  Assumes pins are resolved by the surroundings from out/oe/pull signals and
  that option straps are static levels on pclk.
*/
// Summary of operation
// - Config and data bits select hi-Z input, pulled-up input, drive low, drive high.
// - Ports L, G, C and F have configuration, output data and read-only pin locations; port D has data only.
// - All eight port L pins feed the wake-up detector as well as plain I/O.
// - Port G bit six is always a hi-Z input.
// - With watchdog option, G bit one is watchdog output with pull-up.
// - G bit seven drives oscillator clock for crystal, else wake input on rise.
// - Port G data bits six and seven read back as zero.
// - Writing one to G data bit seven requests HALT.
// - Writing one to G data bit six requests IDLE.
// - G configuration bit six selects the alternate serial shift clock phase.
// - G configuration bit seven enables start-up delay after HALT.
// - G bits zero and two to five are ordinary configurable pins.
// - G bits carry serial, timer and interrupt alternate functions.
// - Port D is output only and forced high during reset.
`timescale 1ns/1ps
module port_io_config #(
  parameter int width = 8
) (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // APB slave
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  input  wire logic [3:0]       pstrb,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  // Option straps
  input  wire logic             watchdog_option,
  input  wire logic [1:0]       clock_option,
  // Port L pins
  input  wire logic [width-1:0] port_l_in,
  output logic      [width-1:0] port_l_out,
  output logic      [width-1:0] port_l_oe,
  output logic      [width-1:0] port_l_pullup,
  output logic                  wakeup_event,
  // Port G pins
  input  wire logic [width-1:0] port_g_in,
  output logic      [width-1:0] port_g_out,
  output logic      [width-1:0] port_g_oe,
  output logic      [width-1:0] port_g_pullup,
  // Port C and F pins
  input  wire logic [width-1:0] port_c_in,
  output logic      [width-1:0] port_c_out,
  output logic      [width-1:0] port_c_oe,
  output logic      [width-1:0] port_c_pullup,
  input  wire logic [width-1:0] port_f_in,
  output logic      [width-1:0] port_f_out,
  output logic      [width-1:0] port_f_oe,
  output logic      [width-1:0] port_f_pullup,
  // Port D pins
  output logic      [width-1:0] port_d_out,
  // Alternate and dedicated functions
  input  wire logic             oscillator_clock_out,
  input  wire logic             watchdog_out_pin,
  input  wire logic             serial_data_out,
  output logic                  serial_data_in,
  output logic                  serial_shift_clock,
  output logic                  timer_io_pin,
  output logic                  timer_capture_pin,
  output logic                  external_interrupt_in,
  output logic                  serial_alt_phase,
  output logic                  halt_startup_delay_enable,
  output logic                  halt_request,
  output logic                  idle_request,
  output logic                  halt_wake
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [width-1:0] port_l_configuration_reg;
  logic [width-1:0] port_l_output_data_reg;
  logic [width-1:0] port_g_configuration_reg;
  logic [width-1:0] port_g_output_data_reg;
  logic [width-1:0] port_c_configuration_reg;
  logic [width-1:0] port_c_output_data_reg;
  logic [width-1:0] port_f_configuration_reg;
  logic [width-1:0] port_f_output_data_reg;
  logic [width-1:0] port_d_data_reg;
  logic             g7_prev_reg;
  logic [width-1:0] l_prev_reg;
  logic [width-1:0] l_sync;
  logic [width-1:0] g_sync;
  logic [width-1:0] c_sync;
  logic [width-1:0] f_sync;
  logic             wr_en;
  logic             rd_en;
  logic             crystal_sel;
  logic [31:0]      rdata_next;
  logic             err_next;

  assign wr_en = psel && penable && pwrite && (pstrb[0] == 1'b1);
  assign rd_en = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign crystal_sel = (clock_option == port_io_pkg::osc_crystal_a) ||
                       (clock_option == port_io_pkg::osc_crystal_b);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  pin_sync #(.width(width)) u_sync_l (.pclk(pclk), .presetn(presetn),
    .async_in(port_l_in), .sync_out(l_sync));
  pin_sync #(.width(width)) u_sync_g (.pclk(pclk), .presetn(presetn),
    .async_in(port_g_in), .sync_out(g_sync));
  pin_sync #(.width(width)) u_sync_c (.pclk(pclk), .presetn(presetn),
    .async_in(port_c_in), .sync_out(c_sync));
  pin_sync #(.width(width)) u_sync_f (.pclk(pclk), .presetn(presetn),
    .async_in(port_f_in), .sync_out(f_sync));

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_l_configuration_reg <= port_io_pkg::port_reset;
      port_l_output_data_reg   <= port_io_pkg::port_reset;
      port_c_configuration_reg <= port_io_pkg::port_reset;
      port_c_output_data_reg   <= port_io_pkg::port_reset;
      port_f_configuration_reg <= port_io_pkg::port_reset;
      port_f_output_data_reg   <= port_io_pkg::port_reset;
      port_g_configuration_reg <= port_io_pkg::port_reset;
      port_g_output_data_reg   <= port_io_pkg::port_reset;
    end else if (wr_en) begin
      if (paddr == port_io_pkg::l_cfg_off) begin
        port_l_configuration_reg <= pwdata[width-1:0];
      end else if (paddr == port_io_pkg::l_data_off) begin
        port_l_output_data_reg <= pwdata[width-1:0];
      end else if (paddr == port_io_pkg::c_cfg_off) begin
        port_c_configuration_reg <= pwdata[width-1:0];
      end else if (paddr == port_io_pkg::c_data_off) begin
        port_c_output_data_reg <= pwdata[width-1:0];
      end else if (paddr == port_io_pkg::f_cfg_off) begin
        port_f_configuration_reg <= pwdata[width-1:0];
      end else if (paddr == port_io_pkg::f_data_off) begin
        port_f_output_data_reg <= pwdata[width-1:0];
      end else if (paddr == port_io_pkg::g_cfg_off) begin
        port_g_configuration_reg <= pwdata[width-1:0];
      end else if (paddr == port_io_pkg::g_data_off) begin
        port_g_output_data_reg <= pwdata[width-1:0];
      end
    end
  end

  // Port D presets high with reset held low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_d_data_reg <= port_io_pkg::d_reset;
    end else if (wr_en && paddr == port_io_pkg::d_data_off) begin
      port_d_data_reg <= pwdata[width-1:0];
    end
  end

  // HALT and IDLE requests are one-cycle pulses on a write of one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      halt_request <= 1'b0;
      idle_request <= 1'b0;
    end else begin
      halt_request <= wr_en && (paddr == port_io_pkg::g_data_off) &&
                      pwdata[port_io_pkg::g_seven_bit];
      idle_request <= wr_en && (paddr == port_io_pkg::g_data_off) &&
                      pwdata[port_io_pkg::g_six_bit];
    end
  end

  // ----------------------------------------
  // Wake detection
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      g7_prev_reg  <= 1'b0;
      l_prev_reg   <= '0;
      halt_wake    <= 1'b0;
      wakeup_event <= 1'b0;
    end else begin
      g7_prev_reg  <= g_sync[port_io_pkg::g_seven_bit];
      l_prev_reg   <= l_sync;
      halt_wake    <= !crystal_sel && !g7_prev_reg &&
                      g_sync[port_io_pkg::g_seven_bit];
      wakeup_event <= |(l_sync ^ l_prev_reg);
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  always_comb begin
    rdata_next = 32'h0000_0000;
    err_next   = 1'b0;
    if (paddr == port_io_pkg::l_cfg_off) begin
      rdata_next[width-1:0] = port_l_configuration_reg;
    end else if (paddr == port_io_pkg::l_data_off) begin
      rdata_next[width-1:0] = port_l_output_data_reg;
    end else if (paddr == port_io_pkg::l_pin_off) begin
      rdata_next[width-1:0] = l_sync;
    end else if (paddr == port_io_pkg::g_cfg_off) begin
      rdata_next[width-1:0] = port_g_configuration_reg;
    end else if (paddr == port_io_pkg::g_data_off) begin
      rdata_next[width-1:0] = port_g_output_data_reg &
                              port_io_pkg::g_data_read_mask;
    end else if (paddr == port_io_pkg::g_pin_off) begin
      rdata_next[width-1:0] = g_sync;
    end else if (paddr == port_io_pkg::c_cfg_off) begin
      rdata_next[width-1:0] = port_c_configuration_reg;
    end else if (paddr == port_io_pkg::c_data_off) begin
      rdata_next[width-1:0] = port_c_output_data_reg;
    end else if (paddr == port_io_pkg::c_pin_off) begin
      rdata_next[width-1:0] = c_sync;
    end else if (paddr == port_io_pkg::f_cfg_off) begin
      rdata_next[width-1:0] = port_f_configuration_reg;
    end else if (paddr == port_io_pkg::f_data_off) begin
      rdata_next[width-1:0] = port_f_output_data_reg;
    end else if (paddr == port_io_pkg::f_pin_off) begin
      rdata_next[width-1:0] = f_sync;
    end else if (paddr == port_io_pkg::d_data_off) begin
      rdata_next[width-1:0] = port_d_data_reg;
    end else if (paddr == port_io_pkg::status_off) begin
      rdata_next[0] = crystal_sel;
      rdata_next[1] = watchdog_option;
    end else begin
      err_next = 1'b1;
    end
  end

  // Zero-wait answer: read data is combinational in the access cycle
  assign prdata  = rd_en ? rdata_next : 32'h0000_0000;
  assign pslverr = psel && penable && err_next;

  // ----------------------------------------
  // Pin mode decode
  // ----------------------------------------
  // Unbonded bits are left to software to set as outputs; nothing here checks it.
  genvar i;
  generate
    for (i = 0; i < width; i++) begin : g_mode
      always_comb begin
        port_l_oe[i]     = port_l_configuration_reg[i];
        port_l_out[i]    = port_l_output_data_reg[i];
        port_l_pullup[i] = !port_l_configuration_reg[i] && port_l_output_data_reg[i];
        port_c_oe[i]     = port_c_configuration_reg[i];
        port_c_out[i]    = port_c_output_data_reg[i];
        port_c_pullup[i] = !port_c_configuration_reg[i] && port_c_output_data_reg[i];
        port_f_oe[i]     = port_f_configuration_reg[i];
        port_f_out[i]    = port_f_output_data_reg[i];
        port_f_pullup[i] = !port_f_configuration_reg[i] && port_f_output_data_reg[i];
      end
    end
  endgenerate

  // Port G: bits 0 and 2..5 are plain pins, 1, 6, 7 special
  always_comb begin
    port_g_oe     = port_g_configuration_reg;
    port_g_out    = port_g_output_data_reg;
    port_g_pullup = ~port_g_configuration_reg & port_g_output_data_reg;
    // Serial data out drives bit 4 when that pin is an output
    port_g_out[port_io_pkg::g_so_bit] = port_g_output_data_reg[port_io_pkg::g_so_bit] |
                                        serial_data_out;
    if (watchdog_option) begin
      port_g_oe[port_io_pkg::g_wd_bit]     = !watchdog_out_pin;
      port_g_out[port_io_pkg::g_wd_bit]    = 1'b0;
      port_g_pullup[port_io_pkg::g_wd_bit] = 1'b1;
    end
    port_g_oe[port_io_pkg::g_six_bit]     = 1'b0;
    port_g_out[port_io_pkg::g_six_bit]    = 1'b0;
    port_g_pullup[port_io_pkg::g_six_bit] = 1'b0;
    port_g_oe[port_io_pkg::g_seven_bit]     = crystal_sel;
    port_g_out[port_io_pkg::g_seven_bit]    = crystal_sel && oscillator_clock_out;
    port_g_pullup[port_io_pkg::g_seven_bit] = 1'b0;
  end

  // ----------------------------------------
  // Alternate functions
  // ----------------------------------------
  assign serial_data_in        = g_sync[port_io_pkg::g_six_bit];
  assign serial_shift_clock    = g_sync[port_io_pkg::g_sk_bit];
  assign timer_io_pin          = g_sync[port_io_pkg::g_tio_bit];
  assign timer_capture_pin     = g_sync[port_io_pkg::g_capt_bit];
  assign external_interrupt_in = g_sync[port_io_pkg::g_external_interrupt_in_bit];
  assign serial_alt_phase          = port_g_configuration_reg[port_io_pkg::g_six_bit];
  assign halt_startup_delay_enable = port_g_configuration_reg[port_io_pkg::g_seven_bit];
  assign port_d_out = port_d_data_reg;
endmodule

/* File: shared/port_io_pkg.sv */
/*
  Package for the port block: register offsets, field positions, reset values.
  Assumes a 32-bit APB with one aligned word per register.
*/
package port_io_pkg;
  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [11:0] l_cfg_off = 12'h000;
  localparam logic [11:0] l_data_off = 12'h004;
  localparam logic [11:0] l_pin_off = 12'h008;
  localparam logic [11:0] g_cfg_off = 12'h00C;
  localparam logic [11:0] g_data_off = 12'h010;
  localparam logic [11:0] g_pin_off = 12'h014;
  localparam logic [11:0] c_cfg_off = 12'h018;
  localparam logic [11:0] c_data_off = 12'h01C;
  localparam logic [11:0] c_pin_off = 12'h020;
  localparam logic [11:0] f_cfg_off = 12'h024;
  localparam logic [11:0] f_data_off = 12'h028;
  localparam logic [11:0] f_pin_off = 12'h02C;
  localparam logic [11:0] d_data_off = 12'h030;
  localparam logic [11:0] status_off = 12'h034;
  // ----------------------------------------
  // Port G field positions
  // ----------------------------------------
  localparam int g_external_interrupt_in_bit = 0;
  localparam int g_wd_bit = 1;
  localparam int g_capt_bit = 2;
  localparam int g_tio_bit = 3;
  localparam int g_so_bit = 4;
  localparam int g_sk_bit = 5;
  localparam int g_six_bit = 6;
  localparam int g_seven_bit = 7;
  // ----------------------------------------
  // Reset values and oscillator option codes
  // ----------------------------------------
  localparam logic [7:0] port_reset = 8'h00;
  localparam logic [7:0] d_reset = 8'hFF;
  localparam logic [7:0] g_data_read_mask = 8'h3F;
  localparam logic [1:0] osc_crystal_a = 2'h2;
  localparam logic [1:0] osc_crystal_b = 2'h3;
endpackage

/* File: verification/pin_model.sv */
/*
  Pin model for one port: outside driver, pull-up and floating lines.
  Assumes the bench never drives a line that the block drives.
*/
`timescale 1ns/1ps
module pin_model #(
  parameter int width = 8
) (
  // Clock
  input  wire logic             pclk,
  // Block side
  input  wire logic [width-1:0] out,
  input  wire logic [width-1:0] oe,
  input  wire logic [width-1:0] pull_en,
  // Outside driver
  input  wire logic [width-1:0] ext,
  input  wire logic [width-1:0] ext_en,
  output logic      [width-1:0] pin
);
  // ----------------------------------------
  // Line resolution
  // ----------------------------------------
  // A floating line wanders each cycle, so no settled value passes a check
  logic [width-1:0] float_reg = '0;
  always @(posedge pclk) float_reg <= ~float_reg;
  always_comb begin
    for (int i = 0; i < width; i++) begin
      if (oe[i]) pin[i] = out[i];
      else if (ext_en[i]) pin[i] = ext[i];
      else if (pull_en[i]) pin[i] = 1'b1;
      else pin[i] = float_reg[i];
    end
  end
endmodule

/* File: verification/port_io_config_asserts.sv */
/*
  Checker for the port block, watching its top-level ports only.
  Assumes one clock, presetn asynchronous active low, writes with pstrb[0] set.
*/
`timescale 1ns/1ps
module port_io_config_asserts #(
  parameter int width = 8
) (
  // Clock, reset and APB
  input wire logic             pclk,
  input wire logic             presetn,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [11:0]      paddr,
  input wire logic [31:0]      pwdata,
  input wire logic [3:0]       pstrb,
  input wire logic [31:0]      prdata,
  input wire logic             pslverr,
  // Straps, pins and requests
  input wire logic             watchdog_option,
  input wire logic [1:0]       clock_option,
  input wire logic [width-1:0] port_l_oe,
  input wire logic [width-1:0] port_l_out,
  input wire logic [width-1:0] port_l_pullup,
  input wire logic [width-1:0] port_g_oe,
  input wire logic [width-1:0] port_g_out,
  input wire logic [width-1:0] port_g_pullup,
  input wire logic [width-1:0] port_d_out,
  input wire logic             oscillator_clock_out,
  input wire logic             watchdog_out_pin,
  input wire logic             serial_alt_phase,
  input wire logic             halt_startup_delay_enable,
  input wire logic             halt_request,
  input wire logic             idle_request
);
  // ----------------------------------------
  // Bus events and properties
  // ----------------------------------------
  wire       acc = psel && penable;
  wire       wr = acc && pwrite && pstrb[0];
  wire [7:0] wbyte = pwdata[7:0];
  wire       crystal = clock_option == port_io_pkg::osc_crystal_a ||
                       clock_option == port_io_pkg::osc_crystal_b;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // A request is one cycle wide, so a held level would stall the core twice
  sequence s_pulse(sig);
    sig ##1 !sig;
  endsequence
  property p_cfg_write; wr && paddr == port_io_pkg::l_cfg_off |=> port_l_oe == $past(wbyte);
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("L enables differ");
  property p_pullup; port_l_pullup == (~port_l_oe & port_l_out); endproperty
  a_pullup: assert property (p_pullup) else $error("L pull-up wrong");
  property p_g6_input; !port_g_oe[6] && !port_g_pullup[6]; endproperty
  a_g6_input: assert property (p_g6_input) else $error("G6 not hi-Z");
  property p_g7_mode; port_g_oe[7] == crystal && (!crystal || port_g_out[7] == oscillator_clock_out);
  endproperty
  a_g7_mode: assert property (p_g7_mode) else $error("G7 mode wrong");
  property p_wd; watchdog_option |-> port_g_oe[1] == !watchdog_out_pin; endproperty
  a_wd: assert property (p_wd) else $error("G1 watchdog drive wrong");
  property p_halt; wr && paddr == port_io_pkg::g_data_off && pwdata[7] |=> s_pulse(halt_request);
  endproperty
  a_halt: assert property (p_halt) else $error("halt pulse wrong");
  property p_idle; wr && paddr == port_io_pkg::g_data_off && pwdata[6] |=> s_pulse(idle_request);
  endproperty
  a_idle: assert property (p_idle) else $error("idle pulse wrong");
  property p_g_read; acc && !pwrite && paddr == port_io_pkg::g_data_off |-> prdata[7:6] == 2'h0;
  endproperty
  a_g_read: assert property (p_g_read) else $error("G data high bits read");
  property p_d_reset; $rose(presetn) |-> port_d_out == 8'hFF; endproperty
  a_d_reset: assert property (p_d_reset) else $error("D not high out of reset");
  property p_g_cfg; wr && paddr == port_io_pkg::g_cfg_off |=>
    {halt_startup_delay_enable, serial_alt_phase} == $past(wbyte[7:6]); endproperty
  a_g_cfg: assert property (p_g_cfg) else $error("G control bits wrong");
endmodule

/* File: verification/port_io_config_tb.sv */
/*
  Bench for the port block: APB master, pin models and a register model.
  Assumes pin reads settle within five edges of a pin change.
*/
`timescale 1ns/1ps
module port_io_config_tb;
  // ----------------------------------------
  // Stimulus, model and observed signals
  // ----------------------------------------
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic        watchdog_option = 1'b0;
  logic [1:0]  clock_option = 2'h0;
  logic        oscillator_clock_out = 1'b0;
  logic        watchdog_out_pin = 1'b1;
  logic        serial_data_out = 1'b0;
  logic [7:0]  ext [4] = '{default: 8'h00};
  logic [7:0]  ext_en [4] = '{default: 8'h00};
  logic [7:0]  cfg_m [4];
  logic [7:0]  dat_m [4];
  logic [7:0]  mask, oe_x, pin_x;
  logic [11:0] base [4] = '{port_io_pkg::l_cfg_off, port_io_pkg::g_cfg_off,
                            port_io_pkg::c_cfg_off, port_io_pkg::f_cfg_off};
  logic [31:0] lfsr = 32'h5559;
  logic [31:0] rd;
  logic        err, seen;
  int          failures = 0;
  int          samples_checked = 0;
  wire  [7:0]  p_out [4], p_oe [4], p_pu [4], pin [4];
  wire  [7:0]  port_d_out;
  wire  [31:0] prdata;
  wire         pready, pslverr, wakeup_event, halt_wake, halt_request, idle_request;
  wire         serial_data_in, serial_shift_clock, timer_io_pin, timer_capture_pin;
  wire         external_interrupt_in, serial_alt_phase, halt_startup_delay_enable;

  always #50 pclk = ~pclk;

  port_io_config #(.width(8)) DUT (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hF), .prdata,
    .pready, .pslverr, .watchdog_option, .clock_option, .wakeup_event, .port_d_out,
    .port_l_in(pin[0]), .port_l_out(p_out[0]), .port_l_oe(p_oe[0]), .port_l_pullup(p_pu[0]),
    .port_g_in(pin[1]), .port_g_out(p_out[1]), .port_g_oe(p_oe[1]), .port_g_pullup(p_pu[1]),
    .port_c_in(pin[2]), .port_c_out(p_out[2]), .port_c_oe(p_oe[2]), .port_c_pullup(p_pu[2]),
    .port_f_in(pin[3]), .port_f_out(p_out[3]), .port_f_oe(p_oe[3]), .port_f_pullup(p_pu[3]),
    .oscillator_clock_out, .watchdog_out_pin, .serial_data_out, .serial_data_in,
    .serial_shift_clock, .timer_io_pin, .timer_capture_pin, .external_interrupt_in,
    .serial_alt_phase, .halt_startup_delay_enable, .halt_request, .idle_request, .halt_wake);

  for (genvar i = 0; i < 4; i++) begin : g_pins
    pin_model #(.width(8)) u_pin (.pclk, .out(p_out[i]), .oe(p_oe[i]), .pull_en(p_pu[i]),
      .ext(ext[i]), .ext_en(ext_en[i]), .pin(pin[i]));
  end

  function automatic logic [31:0] next_rand(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic give_verdict();
    if (failures == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Answer and read data are taken at the rising edge that samples pready high
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) chk("pready", 1, 0);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  initial begin
    #1000000;
    failures++;
    give_verdict();
  end

  initial begin
    repeat (8) @(posedge pclk);
    chk("d_reset", 8'hFF, port_d_out);
    presetn <= 1'b1;
    for (int p = 0; p < 4; p++) begin
      lfsr = next_rand(lfsr);
      cfg_m[p] = lfsr[7:0];
      dat_m[p] = lfsr[15:8];
      mask = (p == 1) ? 8'h3F : 8'hFF;
      oe_x = cfg_m[p] & mask;
      apb(1, base[p], cfg_m[p]);
      apb(1, base[p] + 12'h4, dat_m[p]);
      apb(0, base[p], 0);
      chk("cfg", cfg_m[p], rd);
      apb(0, base[p] + 12'h4, 0);
      chk("data", dat_m[p] & mask, rd);
      @(negedge pclk);
      chk("oe", oe_x, p_oe[p]);
      chk("out", dat_m[p] & oe_x, p_out[p] & oe_x);
      chk("pullup", ~cfg_m[p] & dat_m[p] & mask, p_pu[p]);
      pin_x = (oe_x & dat_m[p]) | (~oe_x & lfsr[23:16]);
      @(posedge pclk);
      ext[p] <= lfsr[23:16];
      ext_en[p] <= ~oe_x;
      repeat (5) @(posedge pclk);
      apb(0, base[p] + 12'h8, 0);
      chk("pins", pin_x, rd);
      if (p == 1) chk("alt", {pin_x[6:5], pin_x[3:2], pin_x[0]}, {serial_data_in,
        serial_shift_clock, timer_io_pin, timer_capture_pin, external_interrupt_in});
    end
    apb(1, port_io_pkg::d_data_off, lfsr[31:24]);
    @(negedge pclk);
    chk("port_d", lfsr[31:24], port_d_out);
    apb(1, port_io_pkg::g_cfg_off, 32'hC0);
    @(negedge pclk);
    chk("g_ctrl", 2'h3, {halt_startup_delay_enable, serial_alt_phase});
    for (int k = 0; k < 2; k++) begin
      apb(1, port_io_pkg::g_data_off, k ? 32'h40 : 32'h80);
      @(negedge pclk);
      chk("request", 1, k ? idle_request : halt_request);
      @(negedge pclk);
      chk("request_end", 0, k ? idle_request : halt_request);
    end
    @(posedge pclk);
    clock_option <= port_io_pkg::osc_crystal_a;
    watchdog_option <= 1'b1;
    serial_data_out <= 1'b1;
    ext_en[1] <= 8'h00;
    for (int k = 0; k < 4; k++) begin
      @(posedge pclk);
      oscillator_clock_out <= k[0];
      watchdog_out_pin <= k[1];
      @(negedge pclk);
      chk("g_dedicated", {2'h2 | k[0], !k[1], 1'b1},
        {p_oe[1][7], p_out[1][7], p_oe[1][1], p_out[1][4]});
    end
    apb(0, port_io_pkg::status_off, 0);
    chk("status", 32'h3, rd);
    clock_option <= 2'h0;
    watchdog_option <= 1'b0;
    ext_en[1] <= 8'h80;
    ext[1] <= 8'h00;
    ext_en[0] <= 8'hFF;
    apb(1, port_io_pkg::l_cfg_off, 0);
    repeat (6) @(posedge pclk);
    for (int k = 0; k < 9; k++) begin
      @(posedge pclk);
      if (k < 8) ext[0] <= ext[0] ^ (8'h01 << k);
      else ext[1] <= 8'h80;
      seen = 0;
      repeat (8) begin
        @(negedge pclk);
        if ((k < 8 ? wakeup_event : halt_wake) === 1'b1) seen = 1;
      end
      chk("wake", 1, seen);
    end
    apb(1, 12'h038, 32'hFF);
    apb(0, 12'h038, 0);
    chk("unmapped_err", 1, err);
    chk("unmapped_rd", 0, rd);
    give_verdict();
  end
endmodule

bind port_io_config port_io_config_asserts #(.width(width)) u_asserts (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pslverr,
  .watchdog_option, .clock_option, .port_l_oe, .port_l_out, .port_l_pullup, .port_g_oe,
  .port_g_out, .port_g_pullup, .port_d_out, .oscillator_clock_out, .watchdog_out_pin,
  .serial_alt_phase, .halt_startup_delay_enable, .halt_request, .idle_request);
